/* File: hw/exec_pkg.sv */
// Package with register map, opcodes, state types and constants.
package exec_pkg;

  // ***************************************************************
  // Register byte addresses on the APB slave.
  // ***************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] BANK_SEL_ADDR = 8'h04;
  localparam logic [7:0] INDEX_BASE_ADDR = 8'h08;
  localparam logic [7:0] PC_ADDR = 8'h0C;
  localparam logic [7:0] INSTR_ADDR = 8'h10;
  localparam logic [7:0] NEXT_WORD_ADDR = 8'h14;
  localparam logic [7:0] STATUS_ADDR = 8'h18;

  // ***************************************************************
  // Field positions and reset values.
  // ***************************************************************
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SKIP_BIT = 1;
  localparam int ST_ILLEGAL_BIT = 2;
  localparam int ST_PHASE_LSB = 4;
  localparam int ST_CYC_LSB = 8;
  localparam int ACCESS_BIT = 8;
  localparam logic [20:0] PC_RESET = 21'h000000;

  // ***************************************************************
  // Opcode fields and addressing constants.
  // ***************************************************************
  localparam logic [4:0] JUMP_TOP5 = 5'h1A;
  localparam logic [3:0] BIT_SET_NIB = 4'h8;
  localparam logic [3:0] TEST_CLEAR_NIB = 4'hB;
  localparam logic [3:0] TEST_SET_NIB = 4'hA;
  localparam logic [7:0] LIT_OFFSET_MAX = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [20:0] WORD_STEP = 21'h000002;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_exec = 3'h2,
    st_flush = 3'h4
  } seq_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic we;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    seq_state_t st;
    logic [1:0] q;
    logic [15:0] ir;
    logic [15:0] nxt;
    logic [20:0] pc;
    logic ext_en;
    logic [3:0] bank_select_reg;
    logic [11:0] idx_base;
    logic [7:0] rdata;
    logic [1:0] flush_left;
    logic [1:0] cyc_cnt;
    logic skipped;
    logic illegal;
    mem_req_t mem;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{st: st_idle, pc: PC_RESET,
                                         default: '0};

endpackage

/* File: hw/bit_unit.sv */
// Single-bit set and test on one data byte.
`timescale 1ns/1ns
module bit_unit #(
  parameter int W = 8
) (
  input wire logic [W-1:0] byte_in,
  input wire logic [$clog2(W)-1:0] bit_sel,
  output logic [W-1:0] set_val,
  output logic bit_val
);
  always_comb begin
    set_val = byte_in;
    set_val[bit_sel] = 1'b1;
    bit_val = byte_in[bit_sel];
  end
endmodule

/* File: hw/branch_bitset_bittest_exec.sv */
// Execution of relative jump, bit-set and bit-test-skip instructions.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
module branch_bitset_bittest_exec
  import exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output mem_req_t mem_req,
  input wire logic [7:0] mem_rdata
);

  // ***************************************************************
  // State and decode.
  // ***************************************************************
  core_state_t s_ff;
  core_state_t nxt_s;
  logic is_jump;
  logic is_set;
  logic is_test;
  logic take_skip;
  logic two_word;
  logic busy;
  logic [11:0] ea;
  logic [20:0] pc_inc;
  logic [20:0] jump_target;
  logic [7:0] set_val;
  logic bit_val;

  assign busy = (s_ff.st != st_idle);
  assign is_jump = (s_ff.ir[15:11] == JUMP_TOP5);
  assign is_set = (s_ff.ir[15:12] == BIT_SET_NIB);
  assign is_test = (s_ff.ir[15:12] == TEST_CLEAR_NIB) ||
                   (s_ff.ir[15:12] == TEST_SET_NIB);
  // The clear form skips on a zero bit, the set form on a one bit.
  assign take_skip = is_test &&
                     (bit_val == (s_ff.ir[15:12] == TEST_SET_NIB));

  // Two-word forms are recognised from the prefetched word so that the
  // flush covers both words without ever executing the second one.
  assign two_word = (s_ff.nxt[15:12] == 4'hC) ||
                    (s_ff.nxt[15:9] == 7'h76) ||
                    (s_ff.nxt[15:8] == 8'hEE) ||
                    (s_ff.nxt[15:8] == 8'hEF);

  assign pc_inc = s_ff.pc + WORD_STEP;
  assign jump_target = pc_inc +
                       {{9{s_ff.ir[10]}}, s_ff.ir[10:0], 1'b0};

  always_comb begin
    if (s_ff.ir[ACCESS_BIT]) begin
      ea = {s_ff.bank_select_reg, s_ff.ir[7:0]};
    end else if (s_ff.ext_en && s_ff.ir[7:0] <= LIT_OFFSET_MAX) begin
      ea = s_ff.idx_base + {4'h0, s_ff.ir[7:0]};
    end else if (s_ff.ir[7]) begin
      ea = {ACCESS_HIGH_BANK, s_ff.ir[7:0]};
    end else begin
      ea = {ACCESS_LOW_BANK, s_ff.ir[7:0]};
    end
  end

  bit_unit #(
    .W(8)
  ) bit_unit_i (
    .byte_in(s_ff.rdata),
    .bit_sel(s_ff.ir[11:9]),
    .set_val(set_val),
    .bit_val(bit_val)
  );

  // ***************************************************************
  // Next state: APB slave and phase sequencer.
  // ***************************************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.pready = 1'b0;
    nxt_s.pslverr = 1'b0;
    nxt_s.mem.rd = 1'b0;
    nxt_s.mem.we = 1'b0;

    // Zero wait states: the answer is registered in the setup cycle.
    if (psel && !penable) begin
      nxt_s.pready = 1'b1;
      nxt_s.prdata = '0;
      case (paddr)
        CTRL_ADDR: nxt_s.prdata[CTRL_EXT_EN_BIT] = s_ff.ext_en;
        BANK_SEL_ADDR: nxt_s.prdata[3:0] = s_ff.bank_select_reg;
        INDEX_BASE_ADDR: nxt_s.prdata[11:0] = s_ff.idx_base;
        PC_ADDR: nxt_s.prdata[20:0] = s_ff.pc;
        INSTR_ADDR: nxt_s.prdata[15:0] = s_ff.ir;
        NEXT_WORD_ADDR: nxt_s.prdata[15:0] = s_ff.nxt;
        STATUS_ADDR: begin
          nxt_s.prdata[ST_BUSY_BIT] = busy;
          nxt_s.prdata[ST_SKIP_BIT] = s_ff.skipped;
          nxt_s.prdata[ST_ILLEGAL_BIT] = s_ff.illegal;
          nxt_s.prdata[ST_PHASE_LSB +: 2] = s_ff.q;
          nxt_s.prdata[ST_CYC_LSB +: 2] = s_ff.cyc_cnt;
        end
        default: nxt_s.pslverr = 1'b1;
      endcase
    end

    // Writes land only while idle, so software never races the core.
    if (psel && penable && s_ff.pready && pwrite && !busy) begin
      case (paddr)
        CTRL_ADDR: nxt_s.ext_en = pwdata[CTRL_EXT_EN_BIT];
        BANK_SEL_ADDR: nxt_s.bank_select_reg = pwdata[3:0];
        INDEX_BASE_ADDR: nxt_s.idx_base = pwdata[11:0];
        PC_ADDR: nxt_s.pc = pwdata[20:0];
        NEXT_WORD_ADDR: nxt_s.nxt = pwdata[15:0];
        INSTR_ADDR: begin
          nxt_s.ir = pwdata[15:0];
          nxt_s.st = st_exec;
          nxt_s.q = 2'h0;
        end
        default: ;
      endcase
    end

    case (s_ff.st)
      st_idle: ;
      st_exec: begin
        nxt_s.q = s_ff.q + 2'h1;
        case (s_ff.q)
          2'h0: begin
            nxt_s.mem.addr = ea;
            nxt_s.mem.rd = is_set || is_test;
          end
          2'h1: nxt_s.rdata = mem_rdata;
          2'h2: begin
            if (is_set) begin
              nxt_s.mem.we = 1'b1;
              nxt_s.mem.wdata = set_val;
            end
          end
          default: begin
            nxt_s.skipped = take_skip;
            nxt_s.illegal = !(is_jump || is_set || is_test);
            if (is_jump) begin
              nxt_s.pc = jump_target;
              nxt_s.flush_left = 2'h1;
            end else if (take_skip) begin
              nxt_s.pc = pc_inc + (two_word ? 21'h4 : WORD_STEP);
              nxt_s.flush_left = two_word ? 2'h2 : 2'h1;
            end else begin
              nxt_s.pc = pc_inc;
              nxt_s.flush_left = 2'h0;
            end
            nxt_s.cyc_cnt = 2'h1 + nxt_s.flush_left;
            nxt_s.st = (nxt_s.flush_left == 2'h0) ? st_idle : st_flush;
          end
        endcase
      end
      st_flush: begin
        nxt_s.q = s_ff.q + 2'h1;
        if (s_ff.q == PHASE_LAST) begin
          nxt_s.flush_left = s_ff.flush_left - 2'h1;
          if (s_ff.flush_left == 2'h1) begin
            nxt_s.st = st_idle;
          end
        end
      end
      default: nxt_s.st = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= CORE_RESET;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign mem_req = s_ff.mem;

  // ***************************************************************
  // Assertions.
  // ***************************************************************
  default clocking cb @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  logic last_exec;
  assign last_exec = (s_ff.st == st_exec) && (s_ff.q == PHASE_LAST);

  sequence s_flush_one;
    (s_ff.st == st_flush) [*4] ##1 (s_ff.st == st_idle);
  endsequence

  sequence s_flush_two;
    (s_ff.st == st_flush) [*8] ##1 (s_ff.st == st_idle);
  endsequence

  a_jump_target: assert property (
    last_exec && is_jump |=> s_ff.pc == $past(jump_target))
    else $error("jump target wrong");

  a_jump_two_cycles: assert property (
    last_exec && s_ff.ir[15:11] == 5'h1A |=> s_flush_one)
    else $error("jump not followed by one empty cycle");

  a_set_writes_bit: assert property (
    s_ff.st == st_exec && s_ff.q == 2'h2 && is_set
    |=> s_ff.mem.we &&
        s_ff.mem.wdata == (s_ff.rdata | (8'h01 << s_ff.ir[11:9])))
    else $error("bit-set write data wrong");

  a_set_one_cycle: assert property (
    s_ff.st == st_exec && s_ff.q == 2'h0 && s_ff.ir[15:12] == 4'h8
    |=> s_ff.mem.rd ##1 !s_ff.mem.we ##1 s_ff.mem.we ##1
        s_ff.st == st_idle)
    else $error("bit-set sequence wrong");

  a_bank_upper: assert property (
    s_ff.st == st_exec && s_ff.q != 2'h0 && s_ff.ir[ACCESS_BIT]
    |-> s_ff.mem.addr[11:8] == s_ff.bank_select_reg)
    else $error("bank bits not from bank select");

  a_indexed_addr: assert property (
    s_ff.st == st_exec && s_ff.q == 2'h1 && !s_ff.ir[ACCESS_BIT] &&
    s_ff.ext_en && s_ff.ir[7:0] <= 8'h5F
    |-> s_ff.mem.addr == s_ff.idx_base + {4'h0, s_ff.ir[7:0]})
    else $error("indexed offset address wrong");

  a_skip_one_word: assert property (
    last_exec && take_skip && !two_word |=> s_flush_one)
    else $error("skip did not flush one word");

  a_no_skip_done: assert property (
    last_exec && is_test && !take_skip |=> s_ff.st == st_idle)
    else $error("untaken test did not finish");

  a_skip_two_words: assert property (
    last_exec && take_skip && two_word
    |=> s_flush_two ##0 s_ff.cyc_cnt == 2'h3)
    else $error("two-word skip not three cycles");

endmodule

/* File: bench/branch_bitset_bittest_exec_test.sv */
// Self-checking bench for the jump, bit-set and bit-test execution block.
`timescale 1ns/1ns
module branch_bitset_bittest_exec_test;
  import exec_pkg::*;
  localparam logic [32:0] FULL = '1;
  localparam logic [32:0] ST_MASK = 33'h1_FFFF_FFCF;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, mem_rdata;
  logic [31:0] pwdata, prdata;
  mem_req_t mem_req;
  logic [7:0] mem [4096];
  logic [32:0] rd_exp [$];
  logic [32:0] rd_mask [$];
  logic [19:0] wr_exp [$];
  int bad_count, check_count;
  logic ext;
  logic [3:0] bank;
  logic [11:0] idx;
  logic [20:0] pc;

  branch_bitset_bittest_exec branch_bitset_bittest_exec_i (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_rdata(mem_rdata));

  // The read strobe and its address land on one edge, so answer at once.
  assign mem_rdata = mem[mem_req.addr];

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ***************************************************************
  // Checking and closing.
  // ***************************************************************
  task automatic close_out();
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [32:0] exp, seen, m);
    check_count++;
    if ((seen & m) !== (exp & m)) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp & m, seen & m);
    end
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      cmp("read", rd_exp.pop_front(), {pslverr, prdata}, rd_mask.pop_front());
    end
    if (mem_req.we === 1'b1) begin
      cmp("mem write", {13'h0, wr_exp.pop_front()},
          {13'h0, mem_req.addr, mem_req.wdata}, FULL);
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end

  // ***************************************************************
  // Bus and instruction tasks.
  // ***************************************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
    rd_exp.push_back(e);
    rd_mask.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
    if (a) return {bank, f};
    if (ext && f <= LIT_OFFSET_MAX) return idx + {4'h0, f};
    return {f[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK, f};
  endfunction

  // A PC write during a long instruction must be dropped by the block.
  task automatic exec(input logic [15:0] ins, nw, input int cyc,
                      input logic sk, il, input logic [20:0] pc_exp);
    apb(1'b1, PC_ADDR, {11'h0, pc});
    apb(1'b1, NEXT_WORD_ADDR, {16'h0, nw});
    apb(1'b1, INSTR_ADDR, {16'h0, ins});
    if (cyc > 1) apb(1'b1, PC_ADDR, 32'h0000_0FF0);
    repeat (4 * cyc) @(posedge pclk);
    rd(PC_ADDR, {12'h0, pc_exp}, FULL);
    rd(STATUS_ADDR, {23'h0, cyc[1:0], 5'h0, il, sk, 1'b0}, ST_MASK);
    pc = pc_exp;
  endtask

  // ***************************************************************
  // Main sequence and watchdog.
  // ***************************************************************
  initial begin
    logic [10:0] off;
    logic a, two, op, sk;
    logic [7:0] f;
    logic [2:0] b;
    logic [11:0] e;
    logic [15:0] nw;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(63503));
    foreach (mem[k]) mem[k] = 8'($urandom);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTRL_ADDR, 33'h0, FULL);
    rd(BANK_SEL_ADDR, 33'h0, FULL);
    rd(PC_ADDR, {12'h0, PC_RESET}, FULL);
    rd(STATUS_ADDR, 33'h0, ST_MASK);
    rd(8'h1C, 33'h1_0000_0000, FULL);
    pc = PC_RESET;
    for (int i = 0; i < 24; i++) begin
      ext = 1'($urandom);
      bank = 4'($urandom);
      idx = 12'($urandom);
      apb(1'b1, CTRL_ADDR, {31'h0, ext});
      apb(1'b1, BANK_SEL_ADDR, {28'h0, bank});
      apb(1'b1, INDEX_BASE_ADDR, {20'h0, idx});
      rd(BANK_SEL_ADDR, {29'h0, bank}, FULL);
      off = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($urandom);
      pc = 21'($urandom) & 21'h1FFFFE;
      exec({JUMP_TOP5, off}, 16'h0, 2, 1'b0, 1'b0,
           pc + WORD_STEP + {{9{off[10]}}, off, 1'b0});
      a = 1'($urandom);
      f = (i % 3 == 0) ? LIT_OFFSET_MAX : (i % 3 == 1) ? 8'h60 : 8'($urandom);
      b = 3'($urandom);
      e = ea(a, f);
      wr_exp.push_back({e, mem[e] | (8'h01 << b)});
      exec({BIT_SET_NIB, b, a, f}, 16'h0, 1, 1'b0, 1'b0,
           pc + WORD_STEP);
      a = 1'($urandom);
      f = 8'($urandom);
      b = 3'($urandom);
      e = ea(a, f);
      two = 1'($urandom);
      case (2'($urandom))
        2'h0: nw = {4'hC, 12'($urandom)};
        2'h1: nw = {7'h76, 9'($urandom)};
        2'h2: nw = {8'hEE, 8'($urandom)};
        default: nw = {8'hEF, 8'($urandom)};
      endcase
      if (!two) nw = {4'h0, 12'($urandom)};
      op = 1'($urandom);
      sk = op ? !mem[e][b] : mem[e][b];
      exec({op ? TEST_CLEAR_NIB : TEST_SET_NIB, b, a, f}, nw,
           sk ? (two ? 3 : 2) : 1, sk, 1'b0,
           pc + (sk ? (two ? 21'h6 : 21'h4) : WORD_STEP));
    end
    // Top bits 11011 are not a jump, so the word runs as unsupported.
    exec({5'h1B, 11'($urandom)}, 16'h0, 1, 1'b0, 1'b1,
         pc + WORD_STEP);
    // Low clock enable must hold the sequencer in mid-instruction.
    apb(1'b1, INSTR_ADDR, 32'h0);
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    rd(STATUS_ADDR, 33'h0_0000_0001, 33'h1_0000_0001);
    repeat (4) @(posedge pclk);
    rd(PC_ADDR, {12'h0, pc + WORD_STEP}, FULL);
    close_out();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    close_out();
  end
endmodule
